// *** verilog/dicr_pkg.sv ***
// Constants shared by the digital input conditioning router
package dicr_pkg;

	// ****************************************
	// Register byte offsets on the slave bus
	// ****************************************
	localparam logic [7:0] OFS_STATUS     = 8'h00; // Input status word, read only
	localparam logic [7:0] OFS_SF_EN      = 8'h04; // Special-function enable mask
	localparam logic [7:0] OFS_INVERT     = 8'h08; // Polarity invert mask
	localparam logic [7:0] OFS_FORCE_EN   = 8'h0c; // Override enable mask
	localparam logic [7:0] OFS_FORCE_VAL  = 8'h10; // Override value
	localparam logic [7:0] OFS_RAW        = 8'h14; // Unmodified sampled levels, read only
	localparam logic [7:0] OFS_ROUTE_EN   = 8'h18; // Routing switch, bit 0
	localparam logic [7:0] OFS_PIN_CFG    = 8'h1c; // Flex pin direction and step mode
	localparam logic [7:0] OFS_FAULT      = 8'h20; // Sticky interlock fault, write 1 clears
	localparam logic [7:0] OFS_TABLE_BASE = 8'h80; // Source table, entry k at base+4*(k-1)
	localparam int         TABLE_IDX_LSB  = 2;     // Word index within the table window
	localparam int         TABLE_ENTRIES  = 32;    // One entry per status bit

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SF_NEG_LIMIT   = 0;  // Negative limit switch
	localparam int SF_POS_LIMIT   = 1;  // Positive limit switch
	localparam int SF_HOME        = 2;  // Home switch
	localparam int SF_INTERLOCK   = 3;  // Interlock release
	localparam int LEVEL_BASE     = 16; // Input n lands on bit LEVEL_BASE+n-1
	localparam int SPECIAL_BITS   = 16; // Bits 0..15 carry special functions
	localparam int CFG_STEP_MODE  = 4;  // Pin config: step-clock mode active
	localparam int PIN_STEP_CLK   = 1;  // Pin index of the step clock (pin 2)
	localparam int PIN_STEP_DIR   = 2;  // Pin index of the step direction (pin 3)
	localparam int FLEX_PINS      = 4;  // Pins that may be outputs
	localparam logic [3:0] STEP_PIN_MASK = 4'h6; // Pins forced to inputs in step mode

	// ****************************************
	// Source select codes
	// ****************************************
	localparam logic [6:0] SRC_ZERO       = 7'h00; // Constant 0 (with bit 7: constant 1)
	localparam logic [6:0] SRC_PHYS_FIRST = 7'h01; // Physical input 1
	localparam logic [6:0] SRC_PHYS_LAST  = 7'h10; // Physical input 16
	localparam logic [6:0] SRC_HALL_U     = 7'h41; // Hall U; V and W follow
	localparam logic [6:0] SRC_ENC_IDX    = 7'h46; // Encoder index; A and B precede
	localparam int         SRC_INV_BIT    = 7;     // Selects inverted source

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [31:0] RST_WORD      = 32'h0000_0000; // All masks clear after reset
	localparam int          CLK_PERIOD_NS = 10;            // 100 MHz system clock
	localparam int          SAMPLE_PERIOD_US = 1000;       // One sample per millisecond
	localparam int          SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;

	// Bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ANSWER = 2'b01
	} dicr_bus_st_t;

endpackage : dicr_pkg

// *** verilog/dicr_tick.sv ***
// Millisecond sampling strobe generator
`timescale 1ns/1ps
module dicr_tick
	import dicr_pkg::*;
#(
	parameter int CYCLES = SAMPLE_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	output logic      o_tick
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_q; // Cycles since the last strobe

	// ****************************************
	// Free-running divider
	// ****************************************
	// Counter wraps at the period and pulses once per wrap
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q  <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 1'b1;
			o_tick <= 1'b0;
		end
	end

endmodule : dicr_tick

// *** verilog/dicr_route_mux.sv ***
// One routing selector: picks a source bit by its code
`timescale 1ns/1ps
module dicr_route_mux
	import dicr_pkg::*;
(
	input  wire logic [7:0]  i_code,
	input  wire logic [15:0] i_phys,
	input  wire logic [2:0]  i_hall,
	input  wire logic [2:0]  i_enc,
	output logic             o_bit
);

	logic [6:0] base_code; // Code without the inversion bit
	logic       base_bit;  // Selected signal before inversion

	// ****************************************
	// Source decode
	// ****************************************
	always_comb begin
		base_code = i_code[6:0];
		base_bit  = 1'b0; // Constant 0 and unknown codes
		if (base_code >= SRC_PHYS_FIRST && base_code <= SRC_PHYS_LAST) begin
			base_bit = i_phys[4'(base_code - SRC_PHYS_FIRST)];
		end else if (base_code >= SRC_HALL_U && base_code < SRC_HALL_U + 7'd3) begin
			base_bit = i_hall[2'(base_code - SRC_HALL_U)];
		end else if (base_code > SRC_ENC_IDX - 7'd3 && base_code <= SRC_ENC_IDX) begin
			base_bit = i_enc[2'(base_code - (SRC_ENC_IDX - 7'd2))];
		end
		o_bit = base_bit ^ i_code[SRC_INV_BIT];
	end

endmodule : dicr_route_mux

// *** verilog/dicr_router.sv ***
// Digital input conditioning and routing block with its register file
//
// Notes on behaviour
// - Special functions appear in status bits 0..15.
// - Input n level sits at bit 15+n.
// - Bit 16 follows input 1 in the fixed mapping; with routing on it follows table entry 17.
// - Output pins readable at 16..19; inputs 5,6 at 20,21.
// - Inputs sampled once per millisecond only.
// - Enable gates special function, not bits 16..31.
// - Enable bits: neg, pos, home, interlock.
// - Invert bit n-1 selects normally-closed input n.
// - Inversion skips step clock and direction inputs in step mode.
// - Force enable replaces sampled value with software's.
// - Force value word gives forced input value.
// - Raw word holds samples before any processing.
// - Bit 0 negative limit; bit 16 input 1.
// - Routing switch selects table-driven status word.
// - Enabling routing preloads table with fixed mapping.
// - Table entry k drives status bit k-1.
// - Code bit 7 selects the inverted source.
// - Interlock bit low raises fault; high permits motion.
// - Interlock acts only when enable bit 3 set.
// - Step mode forces clock and direction pins input.
`timescale 1ns/1ps
module dicr_router
	import dicr_pkg::*;
#(
	parameter int NUM_PINS     = 6,            // Physical digital inputs present
	parameter int TICK_CYCLES  = SAMPLE_CYCLES // Clock cycles per sample
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// Avalon-MM slave
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Pins and sensor lines
	input  wire logic [5:0]  i_pin_level,
	input  wire logic [3:0]  i_pin_drive,
	input  wire logic [2:0]  i_hall,
	input  wire logic [2:0]  i_enc,
	// Results
	output logic [31:0]      o_status_word,
	output logic [3:0]       o_pin_out_en,
	output logic             o_step_clock,
	output logic             o_step_dir,
	output logic             o_motion_permit,
	output logic             o_interlock_fault
);

	// ****************************************
	// Declarations
	// ****************************************
	dicr_bus_st_t bus_st_q;              // Handshake state
	logic [31:0]  sf_en_q;               // Special-function enables
	logic [31:0]  invert_q;              // Polarity invert mask
	logic [31:0]  force_en_q;            // Override enables
	logic [31:0]  force_val_q;           // Override values
	logic         route_en_q;            // Table-driven routing active
	logic [4:0]   pin_cfg_q;             // Flex pin outputs and step mode
	logic [15:0]  raw_q;                 // Sampled pin levels
	logic [2:0]   hall_q;                // Sampled Hall lines
	logic [2:0]   enc_q;                 // Sampled encoder lines
	logic [7:0]   table_q [TABLE_ENTRIES]; // Source codes, index k-1
	logic         tick;                  // Sampling strobe
	logic [3:0]   out_en;                // Effective flex pin outputs
	logic [15:0]  step_mask;             // Inputs exempt from inversion
	logic [15:0]  cond;                  // Forced and inverted inputs
	logic [31:0]  fixed_word;            // Fixed-mapping status
	logic [31:0]  routed_word;           // Table-driven status
	logic [31:0]  status_d;              // Next status word
	logic         permit_d;              // Interlock release
	logic [31:0]  rd_val;                // Read mux result
	logic         req;                   // Any bus request
	logic         wr_go;                 // Write commits this edge
	logic         fault_clr;             // Software clears fault

	// ****************************************
	// Helper functions
	// ****************************************
	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	// Table code that reproduces the fixed mapping for status bit idx
	function automatic logic [7:0] fixed_code(input int idx);
		logic [7:0] code;
		code = {1'b0, SRC_ZERO};
		if (idx >= LEVEL_BASE && idx < LEVEL_BASE + NUM_PINS) begin
			code = 8'(idx - LEVEL_BASE + 1);
		end else if (idx <= SF_INTERLOCK) begin
			code = 8'(idx + 1);
		end
		return code;
	endfunction : fixed_code

	// ****************************************
	// Sampling strobe
	// ****************************************
	dicr_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.o_tick    (tick)
	);

	// ****************************************
	// Pin direction
	// ****************************************
	// Step mode takes clock and direction pins as inputs whatever was written
	always_comb begin
		out_en = pin_cfg_q[3:0];
		if (pin_cfg_q[CFG_STEP_MODE]) begin
			out_en = out_en & ~STEP_PIN_MASK;
		end
	end

	// ****************************************
	// Input sampling
	// ****************************************
	// Pulses shorter than one sample period may be missed, by design
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			raw_q  <= 16'h0000;
			hall_q <= 3'h0;
			enc_q  <= 3'h0;
		end else if (tick) begin
			for (int i = 0; i < 16; i++) begin
				if (i < FLEX_PINS && out_en[i % FLEX_PINS]) begin
					raw_q[i] <= i_pin_drive[i % FLEX_PINS];
				end else if (i < NUM_PINS) begin
					raw_q[i] <= i_pin_level[i % 6];
				end else begin
					raw_q[i] <= 1'b0;
				end
			end
			hall_q <= i_hall;
			enc_q  <= i_enc;
		end
	end

	// ****************************************
	// Conditioning
	// ****************************************
	// Force first, then polarity; step inputs keep their native sense
	always_comb begin
		step_mask = 16'h0000;
		if (pin_cfg_q[CFG_STEP_MODE]) begin
			step_mask[PIN_STEP_CLK] = 1'b1;
			step_mask[PIN_STEP_DIR] = 1'b1;
		end
		for (int i = 0; i < 16; i++) begin
			cond[i] = force_en_q[i] ? force_val_q[i] : raw_q[i];
			cond[i] = cond[i] ^ (invert_q[i] & ~step_mask[i]);
		end
	end

	// ****************************************
	// Fixed mapping
	// ****************************************
	always_comb begin
		fixed_word = 32'h0000_0000;
		for (int i = 0; i < NUM_PINS; i++) begin
			fixed_word[LEVEL_BASE + i] = cond[i];
		end
		for (int f = 0; f <= SF_INTERLOCK; f++) begin
			fixed_word[f] = cond[f];
		end
	end

	// ****************************************
	// Table-driven routing
	// ****************************************
	// One selector per status bit; entry k feeds bit k-1
	for (genvar k = 0; k < TABLE_ENTRIES; k++) begin : g_route
		dicr_route_mux u_mux (
			.i_code (table_q[k]),
			.i_phys (cond),
			.i_hall (hall_q),
			.i_enc  (enc_q),
			.o_bit  (routed_word[k])
		);
	end

	// ****************************************
	// Status word and interlock
	// ****************************************
	// Enables gate only the special half; the level half passes untouched
	always_comb begin
		status_d = route_en_q ? routed_word : fixed_word;
		status_d[SPECIAL_BITS-1:0] = status_d[SPECIAL_BITS-1:0]
			& sf_en_q[SPECIAL_BITS-1:0];
		permit_d = ~sf_en_q[SF_INTERLOCK] | status_d[SF_INTERLOCK];
	end

	// Status and step outputs registered every clock
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_status_word   <= 32'h0000_0000;
			o_step_clock    <= 1'b0;
			o_step_dir      <= 1'b0;
			o_motion_permit <= 1'b1;
			o_pin_out_en    <= 4'h0;
		end else begin
			o_status_word   <= status_d;
			o_step_clock    <= pin_cfg_q[CFG_STEP_MODE] & cond[PIN_STEP_CLK];
			o_step_dir      <= pin_cfg_q[CFG_STEP_MODE] & cond[PIN_STEP_DIR];
			o_motion_permit <= permit_d;
			o_pin_out_en    <= out_en;
		end
	end

	// Sticky fault; a new drop in the clearing cycle keeps it set
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_interlock_fault <= 1'b0;
		end else if (!permit_d) begin
			o_interlock_fault <= 1'b1;
		end else if (fault_clr) begin
			o_interlock_fault <= 1'b0;
		end
	end

	// ****************************************
	// Bus handshake
	// ****************************************
	assign req       = i_avs_read | i_avs_write;
	assign wr_go     = i_avs_write & (bus_st_q == BUS_ANSWER);
	assign fault_clr = wr_go && i_avs_address == OFS_FAULT
		&& i_avs_byteenable[0] && i_avs_writedata[0];

	// Waitrequest drops one cycle after a request and rises right after
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			bus_st_q          <= BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
		end else begin
			case (bus_st_q)
				BUS_IDLE: begin
					if (req) begin
						bus_st_q          <= BUS_ANSWER;
						o_avs_waitrequest <= 1'b0;
						// Writes leave the last read data standing
						if (i_avs_read) begin
							o_avs_readdata <= rd_val;
						end
					end
				end
				BUS_ANSWER: begin
					bus_st_q          <= BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_st_q          <= BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		if (i_avs_address[7]) begin
			rd_val = {24'h00_0000,
				table_q[i_avs_address[TABLE_IDX_LSB +: 5]]};
		end else begin
			case (i_avs_address)
				OFS_STATUS:    rd_val = o_status_word;
				OFS_SF_EN:     rd_val = sf_en_q;
				OFS_INVERT:    rd_val = invert_q;
				OFS_FORCE_EN:  rd_val = force_en_q;
				OFS_FORCE_VAL: rd_val = force_val_q;
				OFS_RAW:       rd_val = {16'h0000, raw_q};
				OFS_ROUTE_EN:  rd_val = {31'h0000_0000, route_en_q};
				OFS_PIN_CFG:   rd_val = {27'h000_0000, pin_cfg_q};
				OFS_FAULT:     rd_val = {31'h0000_0000, o_interlock_fault};
				default:       rd_val = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	// Masks and pin configuration; misaligned or unmapped writes are dropped
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sf_en_q     <= RST_WORD;
			invert_q    <= RST_WORD;
			force_en_q  <= RST_WORD;
			force_val_q <= RST_WORD;
			pin_cfg_q   <= RST_WORD[4:0];
		end else if (wr_go) begin
			case (i_avs_address)
				OFS_SF_EN:     sf_en_q     <= merge(sf_en_q, i_avs_writedata, i_avs_byteenable);
				OFS_INVERT:    invert_q    <= merge(invert_q, i_avs_writedata, i_avs_byteenable);
				OFS_FORCE_EN:  force_en_q  <= merge(force_en_q, i_avs_writedata,
					i_avs_byteenable);
				OFS_FORCE_VAL: force_val_q <= merge(force_val_q, i_avs_writedata,
					i_avs_byteenable);
				OFS_PIN_CFG: begin
					if (i_avs_byteenable[0]) begin
						pin_cfg_q <= i_avs_writedata[4:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Routing switch and table; turning routing on reloads the fixed map
	// so the status word does not jump. Repeated toggling discards edits.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			route_en_q <= 1'b0;
			for (int k = 0; k < TABLE_ENTRIES; k++) begin
				table_q[k] <= fixed_code(k);
			end
		end else if (wr_go && i_avs_byteenable[0]) begin
			if (i_avs_address == OFS_ROUTE_EN) begin
				route_en_q <= i_avs_writedata[0];
				if (i_avs_writedata[0] && !route_en_q) begin
					for (int k = 0; k < TABLE_ENTRIES; k++) begin
						table_q[k] <= fixed_code(k);
					end
				end
			end else if (i_avs_address[7] && i_avs_address[1:0] == 2'b00) begin
				table_q[i_avs_address[TABLE_IDX_LSB +: 5]] <= i_avs_writedata[7:0];
			end
		end
	end

endmodule : dicr_router

// *** testbench/dicr_router_checker.sv ***
// Port-level property checker for the input conditioning router
`timescale 1ns/1ps
module dicr_router_checker
	import dicr_pkg::*;
#(
	parameter int TICK_CYCLES = SAMPLE_CYCLES // Same sample period as the design
) (
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic [7:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic [31:0] o_status_word,
	input wire logic [3:0]  o_pin_out_en,
	input wire logic        o_step_clock,
	input wire logic        o_step_dir,
	input wire logic        o_motion_permit,
	input wire logic        o_interlock_fault
);
	// ****************************************
	// Bus handshake
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Request seen while the slave is idle
	sequence take_s;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	// One cycle of answer, then idle again
	sequence ack_s;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence
	bus_answer_a: assert property (take_s |=> ack_s)
		else $error("bus answer not one cycle after request");
	bus_quiet_a: assert property (!i_avs_read && !i_avs_write && o_avs_waitrequest
		|=> o_avs_waitrequest)
		else $error("bus answered without request");
	rdata_hold_a: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (take_s ##0 (i_avs_read &&
		i_avs_address inside {[8'h24:8'h7c]}) |=> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	// ****************************************
	// Interlock and step pins
	// ****************************************
	permit_hold_a: assert property (o_status_word[SF_INTERLOCK] [*3] |-> o_motion_permit)
		else $error("motion refused with release high");
	fault_raise_a: assert property (!o_motion_permit [*3] |-> o_interlock_fault)
		else $error("release drop left no fault");
	fault_stick_a: assert property (o_interlock_fault && !i_avs_write |=> o_interlock_fault)
		else $error("fault cleared without a write");
	step_clk_in_a: assert property (o_step_clock [*2] |-> !o_pin_out_en[PIN_STEP_CLK])
		else $error("step clock pin still an output");
	step_dir_in_a: assert property (o_step_dir [*2] |-> !o_pin_out_en[PIN_STEP_DIR])
		else $error("step direction pin still an output");
endmodule : dicr_router_checker

bind dicr_router dicr_router_checker #(.TICK_CYCLES(TICK_CYCLES)) u_dicr_router_checker (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_status_word(o_status_word),
	.o_pin_out_en(o_pin_out_en), .o_step_clock(o_step_clock), .o_step_dir(o_step_dir),
	.o_motion_permit(o_motion_permit), .o_interlock_fault(o_interlock_fault)
);

// *** testbench/dicr_io_model.sv ***
// Model of the switches, sensors, Hall and encoder lines at the pins
`timescale 1ns/1ps
module dicr_io_model (
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic [5:0] i_set_level, // Wanted contact levels
	input  wire logic [3:0] i_set_drive, // Wanted driven state of flex pins
	input  wire logic [2:0] i_set_hall,
	input  wire logic [2:0] i_set_enc,
	output logic [5:0]      o_pin_level,
	output logic [3:0]      o_pin_drive,
	output logic [2:0]      o_hall,
	output logic [2:0]      o_enc
);
	// Contacts change on an edge and then rest for many samples, so no bounce
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pin_level <= 6'h00;
			o_pin_drive <= 4'h0;
			o_hall      <= 3'h0;
			o_enc       <= 3'h0;
		end else begin
			o_pin_level <= i_set_level;
			o_pin_drive <= i_set_drive;
			o_hall      <= i_set_hall;
			o_enc       <= i_set_enc;
		end
	end
endmodule : dicr_io_model

// *** testbench/dicr_router_tb.sv ***
// Self-checking bench for the input conditioning router
`timescale 1ns/1ps
module dicr_router_tb
	import dicr_pkg::*;
;
	localparam int TICK = 8; // Short sample period keeps the run brief
	logic        i_clk;
	logic        i_sys_rst;
	logic [7:0]  avs_addr;
	logic        avs_rd;
	logic        avs_wr;
	logic [31:0] avs_wdata;
	logic [31:0] rdata;
	wire  [31:0] rdat_w;
	wire         wreq;
	logic [5:0]  lvl;
	logic [3:0]  drv;
	logic [2:0]  hl;
	logic [2:0]  en;
	wire  [5:0]  pin_lvl;
	wire  [3:0]  pin_drv;
	wire  [2:0]  hall_w;
	wire  [2:0]  enc_w;
	wire  [31:0] status;
	wire  [3:0]  out_en;
	wire         stp_clk;
	wire         stp_dir;
	wire         permit;
	wire         fault;
	int          bad_count;
	int          n_checks;
	int          cyc;
	logic [7:0]  ofs [8] = '{OFS_STATUS, OFS_SF_EN, OFS_INVERT, OFS_FORCE_EN,
		OFS_FORCE_VAL, OFS_RAW, OFS_ROUTE_EN, OFS_FAULT};
	logic [7:0]  codes [18] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h02, 8'h05, 8'h06, 8'h07,
		8'h10, 8'h90, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'hc1, 8'hc6};

	dicr_router #(.NUM_PINS(6), .TICK_CYCLES(TICK)) u_dicr_router (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(avs_addr),
		.i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdat_w), .o_avs_waitrequest(wreq),
		.i_pin_level(pin_lvl), .i_pin_drive(pin_drv), .i_hall(hall_w), .i_enc(enc_w),
		.o_status_word(status), .o_pin_out_en(out_en), .o_step_clock(stp_clk),
		.o_step_dir(stp_dir), .o_motion_permit(permit), .o_interlock_fault(fault));
	dicr_io_model u_dicr_io_model (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_set_level(lvl), .i_set_drive(drv),
		.i_set_hall(hl), .i_set_enc(en), .o_pin_level(pin_lvl), .o_pin_drive(pin_drv),
		.o_hall(hall_w), .o_enc(enc_w));

	// ****************************************
	// Clock, timeout and closing report
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// A hang counts as a mismatch
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	// One bus access: hold until waitrequest is seen low, then release;
	// only the bench timeout ends a wait that never answers
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_addr <= a;
		avs_wdata <= d;
		avs_wr <= w;
		avs_rd <= !w;
		do begin
			@(posedge i_clk);
		end while (wreq !== 1'b0);
		rdata = rdat_w;
		avs_rd <= 1'b0;
		avs_wr <= 1'b0;
		@(posedge i_clk);
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask : rd
	// Long enough for a new sample to reach the status word
	task automatic settle;
		repeat (3 * TICK + 4) @(posedge i_clk);
	endtask : settle
	// Expected routed bit for a source code, from the pins set by the bench
	function automatic logic src_exp(input logic [7:0] c);
		logic v;
		v = 1'b0;
		if (c[6:0] >= 7'h01 && c[6:0] <= 7'h06) v = lvl[c[6:0] - 7'h01];
		if (c[6:0] >= 7'h41 && c[6:0] <= 7'h43) v = hl[c[6:0] - 7'h41];
		if (c[6:0] >= 7'h44 && c[6:0] <= 7'h46) v = en[c[6:0] - 7'h44];
		return v ^ c[7];
	endfunction : src_exp

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_sys_rst = 1'b1;
		{avs_addr, avs_rd, avs_wr, avs_wdata} = '0;
		{lvl, drv, hl, en} = '0;
		{bad_count, n_checks, cyc} = '0;
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		for (int i = 1; i < 5; i++) begin
			wr(ofs[i], 32'ha5c3_3c5a);
			rd(ofs[i], 32'ha5c3_3c5a);
			wr(ofs[i], 32'h0);
		end
		// Read-only and unmapped places ignore writes
		wr(OFS_STATUS, 32'hffff_ffff);
		wr(8'h24, 32'hffff_ffff);
		settle();
		rd(OFS_STATUS, 32'h0);
		rd(8'h24, 32'h0);
		lvl <= 6'h2a;
		settle();
		rd(OFS_RAW, 32'h2a);
		rd(OFS_STATUS, 32'h002a_0000);
		wr(OFS_SF_EN, 32'hf);
		settle();
		rd(OFS_STATUS, 32'h002a_000a);
		wr(OFS_INVERT, 32'h3f);
		settle();
		rd(OFS_STATUS, 32'h0015_0005);
		// Forced value is inverted afterwards
		wr(OFS_FORCE_EN, 32'h1);
		wr(OFS_FORCE_VAL, 32'h1);
		settle();
		rd(OFS_STATUS, 32'h0014_0004);
		rd(OFS_RAW, 32'h2a);
		wr(OFS_INVERT, 32'h0);
		settle();
		rd(OFS_STATUS, 32'h002b_000b);
		wr(OFS_FORCE_EN, 32'h0);
		// Step mode: pins 2 and 3 forced to inputs and left uninverted
		lvl <= 6'h2e;
		wr(OFS_INVERT, 32'h6);
		wr(OFS_PIN_CFG, 32'h16);
		settle();
		rd(OFS_STATUS, 32'h002e_000e);
		chk({26'h0, out_en, stp_clk, stp_dir}, 32'h3);
		wr(OFS_PIN_CFG, 32'h0);
		settle();
		rd(OFS_STATUS, 32'h0028_0008);
		// Flex pin 1 as output reads back its driven state
		wr(OFS_INVERT, 32'h0);
		wr(OFS_PIN_CFG, 32'h1);
		drv <= 4'h1;
		settle();
		rd(OFS_STATUS, 32'h002f_000f);
		chk({28'h0, out_en}, 32'h1);
		wr(OFS_PIN_CFG, 32'h0);
		drv <= 4'h0;
		settle();
		// Routing switched on once; behaviour must not change
		wr(OFS_ROUTE_EN, 32'h1);
		settle();
		rd(OFS_STATUS, 32'h002e_000e);
		chk(status, 32'h002e_000e);
		rd(OFS_TABLE_BASE + 8'h40, 32'h1);
		rd(OFS_TABLE_BASE + 8'h0c, 32'h4);
		hl <= 3'b101;
		en <= 3'b010;
		settle();
		foreach (codes[i]) begin
			wr(OFS_TABLE_BASE + 8'h58, {24'h0, codes[i]});
			repeat (3) @(posedge i_clk);
			bus(1'b0, OFS_STATUS, 32'h0);
			chk({31'h0, rdata[22]}, {31'h0, src_exp(codes[i])});
		end
		// Interlock on input 4 through table entry 4
		wr(OFS_FAULT, 32'h1);
		rd(OFS_FAULT, 32'h0);
		wr(OFS_SF_EN, 32'h8);
		lvl <= 6'h26;
		settle();
		chk({30'h0, permit, fault}, 32'h1);
		rd(OFS_FAULT, 32'h1);
		lvl <= 6'h2e;
		settle();
		chk({30'h0, permit, fault}, 32'h3);
		wr(OFS_FAULT, 32'h1);
		rd(OFS_FAULT, 32'h0);
		wr(OFS_SF_EN, 32'h0);
		lvl <= 6'h26;
		settle();
		chk({30'h0, permit, fault}, 32'h2);
		end_sim();
	end
endmodule : dicr_router_tb
